// *** fe4b_pkg.sv ***
// Purpose: Shared constants and types for the 4B/5B transmit codec
// Assumes: One core clock, synchronous active-high reset
// Notes: Code-group values are the line symbols, MSB first
package fe4b_pkg;

    localparam int FE4B_NIB_W = 4;
    localparam int FE4B_CG_W = 5;
    localparam int FE4B_DIBIT_W = 2;

    // Control code-groups
    localparam logic [4:0] FE4B_CG_IDLE = 5'h1F;
    localparam logic [4:0] FE4B_CG_SSD_J = 5'h18;
    localparam logic [4:0] FE4B_CG_SSD_K = 5'h11;
    localparam logic [4:0] FE4B_CG_ESD_T = 5'h0D;
    localparam logic [4:0] FE4B_CG_ESD_R = 5'h07;
    localparam logic [4:0] FE4B_CG_TXERR = 5'h04;

    // Data code-groups, indexed by nibble value
    localparam logic [4:0] FE4B_DATA_CG [16] = '{
        5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
        5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D
    };

    // Values after reset; rmii mode takes the strap instead, FE4B_RST_RMII is unused
    localparam logic FE4B_RST_RMII = 1'b0;
    localparam logic FE4B_RST_PHASE = 1'b0;
    localparam logic [1:0] FE4B_RST_DIBIT = 2'h0;
    localparam logic FE4B_RST_ER = 1'b0;

    typedef enum logic [1:0] {
        FE4B_ST_IDLE,
        FE4B_ST_SSD_K,
        FE4B_ST_DATA,
        FE4B_ST_ESD_R
    } fe4b_tx_state_t;

endpackage

// *** fe4b_cg_if.sv ***
// Purpose: Carrier between the codec control and its code-group tables
// Assumes: Purely combinational lookups
// Notes: ctl side supplies values, tab side answers
`timescale 1ns/1ps
`default_nettype none
interface fe4b_cg_if;
    logic [3:0] nib;
    logic [4:0] code;
    logic [4:0] rx_sym;
    logic rx_invalid;

    modport ctl (output nib, output rx_sym, input code, input rx_invalid);
    modport tab (input nib, input rx_sym, output code, output rx_invalid);
endinterface
`default_nettype wire

// *** fe4b_cg_table.sv ***
// Purpose: Nibble to code-group map and invalid code-group detector
// Assumes: Combinational, no state
// Notes: Invalid set is every code-group that is neither data nor control
`timescale 1ns/1ps
`default_nettype none
module fe4b_cg_table
    import fe4b_pkg::*;
(
    fe4b_cg_if.tab cg
);

    always_comb begin
        cg.code = FE4B_DATA_CG[cg.nib]; // RULE4
    end

    always_comb begin
        case (cg.rx_sym) // RULE9
            5'h06, 5'h19, 5'h00, 5'h01, 5'h02,
            5'h03, 5'h05, 5'h08, 5'h0C, 5'h10: begin
                cg.rx_invalid = 1'b1;
            end
            default: begin
                cg.rx_invalid = 1'b0;
            end
        endcase
    end

endmodule
`default_nettype wire

// *** fe4b_tx_codec.sv ***
// Purpose: MII/RMII transmit capture, 4B/5B encoding with delimiters,
//          plus receive code-group error and end-of-stream checks
// Assumes: All inputs synchronous to core_clk_i; rst_i is the external
//          reset, synchronous and active high
// Notes: One symbol slot per clock in MII mode and in RMII idle, one per two clocks during an RMII frame
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// [RULE1] MII: take one nibble per clock while enabled
// [RULE2] MAC holds enable exactly over valid data
// [RULE3] RMII: take one dibit per clock while enabled
// [RULE4] Map each data nibble to its code-group
// [RULE5] Send idle after end pair until enable
// [RULE6] Enable rise sends start pair J then K
// [RULE7] Enable fall sends end pair T then R
// [RULE8] Error input during frame sends H symbol
// [RULE9] Never send invalid; flag received invalids
// [RULE10] T then R ends carrier; lone half errors
// [RULE11] Translate disabled passes raw five-bit symbols
// [RULE12] Bypass takes fifth bit from error input
// [RULE13] Bypass honoured only in MII mode
// [RULE14] Latch interface strap at reset release
// [RULE15] In reset send idle, ignore inputs
module fe4b_tx_codec
    import fe4b_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,

    // Configuration
    input wire logic interface_select_strap_i,
    input wire logic translate_en_i,

    // MAC transmit side
    input wire logic tx_en_i,
    input wire logic tx_er_i,
    input wire logic [3:0] txd_i,

    // Symbol output toward the line
    output logic [4:0] sym_o,
    output logic sym_tick_o,
    output logic rmii_mode_o,

    // Receive symbol check
    input wire logic [4:0] rx_sym_i,
    input wire logic rx_sym_valid_i,
    input wire logic rx_dv_i,
    output logic rx_er_o,
    output logic crs_end_o
);

    fe4b_cg_if cg ();

    fe4b_cg_table u_table (
        .cg(cg.tab)
    );

    // Mode strap capture
    logic rst_seen_q;
    logic rst_seen_d;
    logic rmii_q;
    logic rmii_d;

    always_comb begin
        rst_seen_d = rst_i;
        rmii_d = rmii_q;
        if (rst_seen_q && !rst_i) begin
            rmii_d = interface_select_strap_i; // RULE14
        end
    end

    always_ff @(posedge core_clk_i) begin
        rst_seen_q <= rst_seen_d;
        rmii_q <= rmii_d;
    end

    // Transmit capture and slot timing
    fe4b_tx_state_t state_q;
    fe4b_tx_state_t state_d;
    logic phase_q;
    logic phase_d;
    logic [1:0] dibit_lo_q;
    logic [1:0] dibit_lo_d;
    logic er_lo_q;
    logic er_lo_d;
    logic [4:0] sym_q;
    logic [4:0] sym_d;
    logic tick_q;
    logic tick_d;

    logic [3:0] nib;
    logic nib_er;
    logic slot;
    logic bypass;

    always_comb begin
        if (rmii_q) begin
            nib = {txd_i[1:0], dibit_lo_q}; // RULE3
            nib_er = tx_er_i | er_lo_q;
        end else begin
            nib = txd_i; // RULE1
            nib_er = tx_er_i;
        end
        bypass = !translate_en_i && !rmii_q; // RULE13
        slot = !rmii_q || phase_q || (state_q == FE4B_ST_IDLE && !tx_en_i);
    end

    always_comb begin
        cg.nib = nib;
        cg.rx_sym = rx_sym_i;
    end

    always_comb begin
        state_d = state_q;
        sym_d = sym_q;
        tick_d = slot;
        dibit_lo_d = dibit_lo_q;
        er_lo_d = er_lo_q;
        phase_d = phase_q;
        if (rmii_q) begin
            if (state_q == FE4B_ST_IDLE && !tx_en_i) begin
                phase_d = FE4B_RST_PHASE;
            end else begin
                phase_d = !phase_q;
            end
            if (!phase_q) begin
                dibit_lo_d = txd_i[1:0];
                er_lo_d = tx_er_i;
            end
        end
        if (slot) begin
            case (state_q)
                FE4B_ST_IDLE: begin
                    if (tx_en_i) begin
                        sym_d = FE4B_CG_SSD_J; // RULE6
                        state_d = FE4B_ST_SSD_K;
                    end else begin
                        sym_d = FE4B_CG_IDLE; // RULE5
                    end
                end
                FE4B_ST_SSD_K: begin
                    if (tx_en_i) begin
                        sym_d = FE4B_CG_SSD_K; // RULE6
                        state_d = FE4B_ST_DATA;
                    end else begin
                        sym_d = FE4B_CG_ESD_T; // RULE7
                        state_d = FE4B_ST_ESD_R;
                    end
                end
                FE4B_ST_DATA: begin
                    if (!tx_en_i) begin
                        sym_d = FE4B_CG_ESD_T; // RULE7
                        state_d = FE4B_ST_ESD_R;
                    end else if (bypass) begin
                        sym_d = {nib_er, nib}; // RULE11 RULE12
                    end else if (nib_er) begin
                        sym_d = FE4B_CG_TXERR; // RULE8
                    end else begin
                        sym_d = cg.code; // RULE4
                    end
                end
                FE4B_ST_ESD_R: begin
                    sym_d = FE4B_CG_ESD_R; // RULE7
                    state_d = FE4B_ST_IDLE;
                end
                default: begin
                    sym_d = FE4B_CG_IDLE;
                    state_d = FE4B_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_q <= FE4B_ST_IDLE; // RULE15
            sym_q <= FE4B_CG_IDLE; // RULE15
            tick_q <= 1'b0;
            phase_q <= FE4B_RST_PHASE;
            dibit_lo_q <= FE4B_RST_DIBIT;
            er_lo_q <= FE4B_RST_ER;
        end else begin
            state_q <= state_d;
            sym_q <= sym_d;
            tick_q <= tick_d;
            phase_q <= phase_d;
            dibit_lo_q <= dibit_lo_d;
            er_lo_q <= er_lo_d;
        end
    end

    // Receive code-group checks
    logic t_pend_q;
    logic t_pend_d;
    logic rx_er_q;
    logic rx_er_d;
    logic crs_end_q;
    logic crs_end_d;

    always_comb begin
        t_pend_d = t_pend_q;
        rx_er_d = 1'b0;
        crs_end_d = 1'b0;
        if (rx_sym_valid_i) begin
            if (t_pend_q) begin
                t_pend_d = 1'b0;
                if (rx_sym_i == FE4B_CG_ESD_R) begin
                    crs_end_d = 1'b1; // RULE10
                end else begin
                    rx_er_d = 1'b1; // RULE10
                end
            end else if (rx_sym_i == FE4B_CG_ESD_T) begin
                t_pend_d = 1'b1;
            end else if (rx_sym_i == FE4B_CG_ESD_R) begin
                rx_er_d = 1'b1; // RULE10
            end else if (cg.rx_invalid && rx_dv_i) begin
                rx_er_d = 1'b1; // RULE9
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            t_pend_q <= 1'b0;
            rx_er_q <= 1'b0;
            crs_end_q <= 1'b0;
        end else begin
            t_pend_q <= t_pend_d;
            rx_er_q <= rx_er_d;
            crs_end_q <= crs_end_d;
        end
    end

    // Outputs
    assign sym_o = sym_q;
    assign sym_tick_o = tick_q;
    assign rmii_mode_o = rmii_q;
    assign rx_er_o = rx_er_q;
    assign crs_end_o = crs_end_q;

endmodule
`default_nettype wire

// *** fe4b_mac_model.sv ***
// Purpose: MAC side model that drives the codec transmit inputs
// Assumes: Inputs change at the falling edge of the core clock
// Notes: Between frames the data lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module fe4b_mac_model (
    // Clock
    input wire logic clk_i,
    // Transmit side
    output logic tx_en_o,
    output logic tx_er_o,
    output logic [3:0] txd_o
);
    initial begin
        tx_en_o = 1'b0;
        tx_er_o = 1'b0;
        txd_o = 4'h0;
    end
    // Each entry is {er, nibble}; RMII sends the low dibit first
    task automatic send(input logic [4:0] f[$], input logic rmii);
        foreach (f[i]) begin
            for (int p = 0; p <= int'(rmii); p++) begin
                @(negedge clk_i);
                tx_en_o = 1'b1;
                tx_er_o = f[i][4];
                txd_o = rmii ? {2'h0, (p == 0) ? f[i][1:0] : f[i][3:2]} : f[i][3:0];
            end
        end
        @(negedge clk_i);
        tx_en_o = 1'b0;
        tx_er_o = 1'b0;
        txd_o = ~txd_o;
    endtask
endmodule
`default_nettype wire

// *** fe4b_tx_codec_chk.sv ***
// Purpose: Port assertions for the 4B/5B transmit codec
// Assumes: One clock, synchronous active-high reset
// Notes: Transmit checks cover MII; RMII is judged by the bench
`timescale 1ns/1ps
`default_nettype none
module fe4b_tx_codec_chk
    import fe4b_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Inputs
    input wire logic interface_select_strap_i,
    input wire logic translate_en_i,
    input wire logic tx_en_i,
    input wire logic tx_er_i,
    input wire logic [3:0] txd_i,
    input wire logic [4:0] rx_sym_i,
    input wire logic rx_sym_valid_i,
    input wire logic rx_dv_i,
    // Outputs
    input wire logic [4:0] sym_o,
    input wire logic sym_tick_o,
    input wire logic rmii_mode_o,
    input wire logic rx_er_o,
    input wire logic crs_end_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // Third or later nibble of an MII frame
    sequence s_dat;
        !rmii_mode_o && tx_en_i && $past(tx_en_i) && $past(tx_en_i, 2);
    endsequence
    chk_reset_idle: assert property ($past(rst_i) |-> sym_o == FE4B_CG_IDLE && !sym_tick_o)
        else $error("not idle after reset");
    chk_mode_latch: assert property ($fell(rst_i) |=> rmii_mode_o == $past(interface_select_strap_i))
        else $error("mode not latched");
    chk_mode_hold: assert property (!$past(rst_i) && !$past(rst_i, 2) |-> $stable(rmii_mode_o))
        else $error("mode changed");
    chk_start_pair: assert property (!rmii_mode_o && $rose(tx_en_i) ##1 tx_en_i
        |-> sym_o == FE4B_CG_SSD_J ##1 sym_o == FE4B_CG_SSD_K) else $error("bad start pair");
    chk_end_pair: assert property (!rmii_mode_o && $fell(tx_en_i) |=> sym_o == FE4B_CG_ESD_T
        ##1 sym_o == FE4B_CG_ESD_R ##1 sym_o == FE4B_CG_IDLE) else $error("bad end pair");
    chk_data_map: assert property (s_dat ##0 (translate_en_i && !tx_er_i)
        |=> sym_o == FE4B_DATA_CG[$past(txd_i)]) else $error("bad data code");
    chk_err_sym: assert property (s_dat ##0 (translate_en_i && tx_er_i)
        |=> sym_o == FE4B_CG_TXERR) else $error("no error symbol");
    chk_bypass_raw: assert property (s_dat ##0 !translate_en_i
        |=> sym_o == {$past(tx_er_i), $past(txd_i)}) else $error("bad raw symbol");
    chk_no_invalid: assert property ((translate_en_i || rmii_mode_o) |-> !(sym_o inside {5'h06, 5'h19,
        5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h08, 5'h0C, 5'h10})) else $error("invalid sent");
    chk_rx_invalid: assert property (rx_sym_valid_i && rx_dv_i && (rx_sym_i inside {5'h06,
        5'h19, 5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h08, 5'h0C, 5'h10}) |=> rx_er_o)
        else $error("invalid not flagged");
    chk_esd_end: assert property (rx_sym_valid_i && rx_sym_i == FE4B_CG_ESD_T ##1
        rx_sym_valid_i && rx_sym_i == FE4B_CG_ESD_R |=> crs_end_o && !rx_er_o)
        else $error("no carrier end");
    chk_lone_t: assert property (rx_sym_valid_i && rx_sym_i == FE4B_CG_ESD_T ##1
        rx_sym_valid_i && rx_sym_i != FE4B_CG_ESD_R |=> rx_er_o) else $error("lone half");
    cover property (s_dat ##0 tx_er_i);
    cover property (!rmii_mode_o && $fell(tx_en_i));
    cover property (crs_end_o);
    cover property (s_dat ##0 !translate_en_i);
    cover property (rmii_mode_o && $rose(tx_en_i));
endmodule
bind fe4b_tx_codec fe4b_tx_codec_chk u_fe4b_tx_codec_chk (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .interface_select_strap_i(interface_select_strap_i),
    .translate_en_i(translate_en_i), .tx_en_i(tx_en_i), .tx_er_i(tx_er_i), .txd_i(txd_i),
    .rx_sym_i(rx_sym_i), .rx_sym_valid_i(rx_sym_valid_i), .rx_dv_i(rx_dv_i), .sym_o(sym_o),
    .sym_tick_o(sym_tick_o), .rmii_mode_o(rmii_mode_o), .rx_er_o(rx_er_o),
    .crs_end_o(crs_end_o));
`default_nettype wire

// *** tb_fe4b_tx_codec.sv ***
// Purpose: Self-checking bench for the 4B/5B transmit codec
// Assumes: 20 MHz core clock, inputs driven on the falling edge
// Notes: Non-idle symbols are collected on each slot tick
`timescale 1ns/1ps
`default_nettype none
module tb_fe4b_tx_codec
    import fe4b_pkg::*;
;
    logic core_clk_i, rst_i, strap, xlat, tx_en, tx_er, tick, mode;
    logic rx_valid, rx_dv, rx_er, crs_end;
    logic [3:0] txd;
    logic [4:0] sym, rx_sym;
    logic [4:0] got[$], exp[$], f[$];
    logic [4:0] inv[10] = '{5'h06, 5'h19, 5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h08, 5'h0C, 5'h10};
    int err_total = 0;
    int compares = 0;
    fe4b_mac_model u_fe4b_mac_model (.clk_i(core_clk_i), .tx_en_o(tx_en), .tx_er_o(tx_er),
        .txd_o(txd));
    fe4b_tx_codec u_fe4b_tx_codec (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .interface_select_strap_i(strap), .translate_en_i(xlat), .tx_en_i(tx_en),
        .tx_er_i(tx_er), .txd_i(txd), .sym_o(sym), .sym_tick_o(tick), .rmii_mode_o(mode),
        .rx_sym_i(rx_sym), .rx_sym_valid_i(rx_valid), .rx_dv_i(rx_dv), .rx_er_o(rx_er),
        .crs_end_o(crs_end));
    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i)
        if (tick === 1'b1 && sym !== FE4B_CG_IDLE) got.push_back(sym);
    task automatic chk(input logic c, input string m);
        compares++;
        if (c !== 1'b1) begin
            err_total++;
            $display("CHECK FAILED t=%0t %s", $time, m);
        end
    endtask
    task automatic summarize();
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic do_reset(input logic s);
        rst_i = 1'b1;
        strap = s;
        repeat (5) @(negedge core_clk_i);
        chk(sym === FE4B_CG_IDLE && tick === 1'b0, "idle in reset");
        rst_i = 1'b0;
        @(negedge core_clk_i);
        strap = ~s;
        @(negedge core_clk_i);
        chk(mode === s, "mode strap");
        $display("test reset done");
    endtask
    task automatic run_frame(input logic rmii, input string name);
        got.delete();
        exp = '{FE4B_CG_SSD_J, FE4B_CG_SSD_K};
        for (int i = 2; i < f.size(); i++)
            if (!xlat && !rmii) exp.push_back(f[i]);
            else if (f[i][4]) exp.push_back(FE4B_CG_TXERR);
            else exp.push_back(FE4B_DATA_CG[f[i][3:0]]);
        exp.push_back(FE4B_CG_ESD_T);
        exp.push_back(FE4B_CG_ESD_R);
        u_fe4b_mac_model.send(f, rmii);
        for (int n = 0; got.size() < exp.size(); n++) begin
            if (n == 20) begin
                chk(1'b0, "frame timeout");
                summarize();
            end
            @(negedge core_clk_i);
        end
        @(negedge core_clk_i);
        chk(sym === FE4B_CG_IDLE, "idle after end");
        foreach (exp[i]) chk(got[i] === exp[i], "symbol");
        $display("test %s done", name);
    endtask
    task automatic t_mii();
        f = '{5'h05, 5'h05};
        for (int i = 0; i < 16; i++) f.push_back({i == 9, 4'(i)});
        run_frame(1'b0, "mii");
    endtask
    task automatic t_bypass();
        xlat = 1'b0;
        f = '{5'h05, 5'h05, 5'h13, 5'h0A, 5'h04};
        run_frame(1'b0, "bypass");
        xlat = 1'b1;
    endtask
    task automatic t_rmii();
        do_reset(1'b1);
        xlat = 1'b0;
        t_mii_frame_rmii();
    endtask
    task automatic t_mii_frame_rmii();
        f = '{5'h05, 5'h05, 5'h00, 5'h1A, 5'h07};
        run_frame(1'b1, "rmii");
    endtask
    task automatic rx(input logic [4:0] s, input logic dv, input logic er, input logic crs);
        rx_sym = s;
        rx_valid = 1'b1;
        rx_dv = dv;
        @(negedge core_clk_i);
        chk(rx_er === er && crs_end === crs, "receive check");
    endtask
    task automatic t_rx();
        foreach (inv[i]) rx(inv[i], 1'b1, 1'b1, 1'b0);
        rx(5'h00, 1'b0, 1'b0, 1'b0);
        rx(FE4B_CG_ESD_T, 1'b1, 1'b0, 1'b0);
        rx(FE4B_CG_ESD_R, 1'b1, 1'b0, 1'b1);
        rx(FE4B_CG_ESD_T, 1'b1, 1'b0, 1'b0);
        rx(5'h1E, 1'b1, 1'b1, 1'b0);
        rx(FE4B_CG_ESD_R, 1'b1, 1'b1, 1'b0);
        rx_valid = 1'b0;
        $display("test rx done");
    endtask
    initial begin
        {rx_valid, rx_dv, rx_sym} = 7'h00;
        xlat = 1'b1;
        do_reset(1'b0);
        t_mii();
        t_bypass();
        t_rmii();
        t_rx();
        summarize();
    end
endmodule
`default_nettype wire
